// >>> acs_defines.vh
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
// Register byte offsets
`define ACS_OFF_CTRL      12'h000
`define ACS_OFF_SETUP     12'h004
`define ACS_OFF_STATUS    12'h008
`define ACS_OFF_RESULT    12'h00C
`define ACS_OFF_IRQ_STAT  12'h010
`define ACS_OFF_IRQ_EN    12'h014
`define ACS_OFF_IRQ_CLR   12'h018
// CTRL fields
`define ACS_CTRL_GO       0
`define ACS_CTRL_CH_LSB   8
`define ACS_CTRL_CH_W     5
// SETUP fields
`define ACS_SET_ACQ_LSB   0
`define ACS_SET_RES_LSB   8
`define ACS_SET_CAL       16
// Reset values
`define ACS_SETUP_RST     32'h0001_0A00
// STATUS fields
`define ACS_ST_BUSY       0
`define ACS_ST_ACQ        1
`define ACS_ST_VALID      2
// Interrupt bits
`define ACS_IRQ_DONE      0
`define ACS_IRQ_START     1
`define ACS_IRQ_W         2
// Timing counts in converter clock periods
`define ACS_ACQ_BASE      9'h002
`define ACS_CAL_CYCLES    9'h002
// Converter clock divider from pclk
`define ACS_CONV_DIV      4
`endif

// >>> acs_clk_div.v
`timescale 1ns/1ns
`include "acs_defines.vh"
module acs_clk_div #(
   parameter DIV = `ACS_CONV_DIV
) (
   // Clock and reset
   input  wire pclk,
   input  wire presetn,
   // Converter clock enable pulse
   output reg  tick
);
   reg [7:0] cnt_q; // Divider count

   // One-cycle enable every DIV pclk periods
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
         tick  <= 1'b0;
      end else if (cnt_q == DIV[7:0] - 8'h01) begin
         cnt_q <= 8'h00;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         tick  <= 1'b0;
      end
   end
endmodule

// >>> acs_sync2.v
`timescale 1ns/1ns
module acs_sync2 (
   // Clock and reset
   input  wire pclk,
   input  wire presetn,
   // Asynchronous level in, synchronised out
   input  wire d,
   output reg  q
);
   reg meta_q; // First stage, read only by q

   // Two flops against metastability
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// >>> acs_sequencer.v
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "acs_defines.vh"
module acs_sequencer #(
   parameter RES_MAX = 12,
   parameter DIV     = `ACS_CONV_DIV
) (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Fabric side
   input  wire        conversion_go,
   input  wire [11:0] sample_in,
   // Status outputs
   output reg         busy,
   output reg         acquiring,
   output reg         result_valid,
   output reg  [11:0] result,
   output reg  [4:0]  result_channel,
   output reg         irq
);
   // Phase states
   localparam ST_IDLE = 2'b00;
   localparam ST_ACQ  = 2'b01;
   localparam ST_DIST = 2'b10;
   localparam ST_CAL  = 2'b11;

   reg  [1:0]  state_q;      // Sequencer phase
   reg  [8:0]  cnt_q;        // Cycles left in phase
   reg  [31:0] setup_q;      // Acquisition, resolution, calibration
   reg  [4:0]  chan_q;       // Channel for next conversion
   reg  [4:0]  cur_chan_q;   // Channel in flight
   reg         sw_go_q;      // Software start pulse
   reg         pend_q;       // Start waiting for converter
   reg         go_prev_q;    // Edge detect on synced go
   reg         done_q;       // Result synchronisation stage
   reg  [11:0] sample_q;     // Sample captured at end of distribution
   reg  [`ACS_IRQ_W-1:0] irq_stat_q; // Sticky events
   reg  [`ACS_IRQ_W-1:0] irq_en_q;   // Event enables
   wire        go_sync;      // Pin go after two flops
   wire        tick;         // Converter clock enable
   wire        go_rise;
   wire        start_req;
   wire        wr;
   wire        rd;
   wire [7:0]  acq_set;
   wire [4:0]  res_bits;
   wire        cal_en;
   reg         ev_start;
   reg         ev_done;

   // Pin start is asynchronous to pclk
   acs_sync2 u_go_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (conversion_go),
      .q       (go_sync)
   );

   // Converter clock as an enable
   acs_clk_div #(.DIV(DIV)) u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick)
   );

   // Setup field decode, start request and APB strobes
   assign acq_set  = setup_q[`ACS_SET_ACQ_LSB +: 8];
   assign res_bits = setup_q[`ACS_SET_RES_LSB +: 5];
   assign cal_en   = setup_q[`ACS_SET_CAL];
   assign go_rise  = go_sync & ~go_prev_q;
   assign start_req = go_rise | sw_go_q;
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;

   // Clamp resolution so distribution never runs zero cycles
   function [8:0] dist_len;
      input [4:0] bits;
      begin
         if (bits == 5'h00)
            dist_len = 9'h001;
         else if (bits > RES_MAX[4:0])
            dist_len = {4'h0, RES_MAX[4:0]};
         else
            dist_len = {4'h0, bits};
      end
   endfunction

   // Start capture and pending flag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         go_prev_q <= 1'b0;
         pend_q    <= 1'b0;
      end else begin
         go_prev_q <= go_sync;
         // one conversion at a time, start waits
         if (start_req)
            pend_q <= 1'b1;
         else if (tick && state_q == ST_IDLE)
            pend_q <= 1'b0;
      end
   end

   // Phase sequencer on converter ticks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= ST_IDLE;
         cnt_q      <= 9'h000;
         busy       <= 1'b0;
         acquiring  <= 1'b0;
         done_q     <= 1'b0;
         sample_q   <= 12'h000;
         cur_chan_q <= 5'h00;
         ev_start   <= 1'b0;
      end else begin
         done_q   <= 1'b0;
         ev_start <= 1'b0;
         if (tick) begin
            case (state_q)
               ST_IDLE: begin
                  if (pend_q) begin
                     busy       <= 1'b1;
                     acquiring  <= 1'b1;
                     cur_chan_q <= chan_q;
                     ev_start   <= 1'b1;
                     cnt_q   <= {1'b0, acq_set} + `ACS_ACQ_BASE - 9'h001;
                     state_q <= ST_ACQ;
                  end
               end
               ST_ACQ: begin
                  if (cnt_q == 9'h000) begin
                     acquiring <= 1'b0;
                     cnt_q   <= dist_len(res_bits) - 9'h001;
                     state_q <= ST_DIST;
                  end else
                     cnt_q <= cnt_q - 9'h001;
               end
               ST_DIST: begin
                  if (cnt_q == 9'h000) begin
                     sample_q <= sample_in;
                     if (cal_en) begin
                        cnt_q   <= `ACS_CAL_CYCLES - 9'h001;
                        state_q <= ST_CAL;
                     end else begin
                        busy    <= 1'b0;
                        done_q  <= 1'b1;
                        state_q <= ST_IDLE;
                     end
                  end else
                     cnt_q <= cnt_q - 9'h001;
               end
               ST_CAL: begin
                  if (cnt_q == 9'h000) begin
                     busy    <= 1'b0;
                     done_q  <= 1'b1;
                     state_q <= ST_IDLE;
                  end else
                     cnt_q <= cnt_q - 9'h001;
               end
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Result register and valid flag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_valid   <= 1'b0;
         result         <= 12'h000;
         result_channel <= 5'h00;
         ev_done        <= 1'b0;
      end else begin
         ev_done <= done_q;
         // valid one pclk after busy falls
         if (done_q) begin
            result_valid   <= 1'b1;
            result         <= sample_q;
            result_channel <= cur_chan_q;
         end else if (start_req)
            result_valid <= 1'b0;
      end
   end

   // APB registers, zero wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setup_q  <= `ACS_SETUP_RST;
         chan_q   <= 5'h00;
         sw_go_q  <= 1'b0;
         irq_en_q <= {`ACS_IRQ_W{1'b0}};
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         prdata   <= 32'h0000_0000;
      end else begin
         sw_go_q <= 1'b0;
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            // Unmapped offsets answer with an error
            case (paddr)
               `ACS_OFF_CTRL, `ACS_OFF_SETUP, `ACS_OFF_STATUS, `ACS_OFF_RESULT,
               `ACS_OFF_IRQ_STAT, `ACS_OFF_IRQ_EN, `ACS_OFF_IRQ_CLR:
                  pslverr <= 1'b0;
               default: pslverr <= 1'b1;
            endcase
         end
         if (wr && pready) begin
            case (paddr)
               `ACS_OFF_CTRL: begin
                  sw_go_q <= pwdata[`ACS_CTRL_GO];
                  chan_q  <= pwdata[`ACS_CTRL_CH_LSB +: `ACS_CTRL_CH_W];
               end
               `ACS_OFF_SETUP:  setup_q  <= pwdata & 32'h0001_1FFF;
               `ACS_OFF_IRQ_EN: irq_en_q <= pwdata[`ACS_IRQ_W-1:0];
               default: ;
            endcase
         end
         if (rd) begin
            case (paddr)
               `ACS_OFF_CTRL:   prdata <= {19'h0, chan_q, 8'h00};
               `ACS_OFF_SETUP:  prdata <= setup_q;
               `ACS_OFF_STATUS: prdata <= {29'h0, result_valid, acquiring, busy};
               `ACS_OFF_RESULT: prdata <= {11'h0, result_channel, 4'h0, result};
               `ACS_OFF_IRQ_STAT: prdata <= {30'h0, irq_stat_q};
               `ACS_OFF_IRQ_EN: prdata <= {30'h0, irq_en_q};
               default:         prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Sticky events, set wins over clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= {`ACS_IRQ_W{1'b0}};
         irq        <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q &
                        ~((wr && pready && paddr == `ACS_OFF_IRQ_CLR) ?
                          pwdata[`ACS_IRQ_W-1:0] : {`ACS_IRQ_W{1'b0}}))
                       | {ev_start, ev_done};
         irq <= |(irq_stat_q & irq_en_q);
      end
   end
endmodule

// >>> acs_monitor.sv
`timescale 1ns/1ns
module acs_monitor (
   // Clock and reset
   input wire        pclk,
   input wire        presetn,
   // Bus snoop
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire        pready,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   // Converter side
   input wire        conversion_go,
   input wire        busy,
   input wire        acquiring,
   input wire        result_valid,
   input wire [11:0] result,
   input wire [4:0]  result_channel
);
   reg [7:0]  s_q;    // Shadow acquisition length
   reg [4:0]  n_q;    // Shadow resolution
   reg        c_q;    // Shadow calibration enable
   reg [11:0] acq_q;  // Cycles spent acquiring
   reg [11:0] dst_q;  // Cycles busy after acquiring
   reg [3:0]  go_q;   // Cycles since last go request
   wire wr = psel & penable & pready & pwrite;
   wire [11:0] acq_len = ({4'h0, s_q} + 12'h002) << 2;
   wire [11:0] dst_len = ({7'h00, n_q} + (c_q ? 12'h002 : 12'h000)) << 2;
   // Shadow settings and phase counters
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= 8'h00; n_q <= 5'h0A; c_q <= 1'b1;
         acq_q <= 12'h000; dst_q <= 12'h000; go_q <= 4'hF;
      end else begin
         if (wr && paddr == 12'h004) begin
            s_q <= pwdata[7:0]; n_q <= pwdata[12:8]; c_q <= pwdata[16];
         end
         acq_q <= acquiring ? acq_q + 12'h001 : 12'h000;
         dst_q <= (busy && !acquiring) ? dst_q + 12'h001 : 12'h000;
         // Saturate so a stale request never looks recent
         if (conversion_go || (wr && paddr == 12'h000 && pwdata[0])) go_q <= 4'h0;
         else if (go_q != 4'hF) go_q <= go_q + 4'h1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_acq_len: assert property ($fell(acquiring) |-> acq_q == acq_len)
      else $error("acquire length wrong");
   a_dist_busy: assert property ($fell(acquiring) |-> busy)
      else $error("busy fell with acquiring");
   a_dist_len: assert property ($fell(busy) && !c_q |-> dst_q == dst_len)
      else $error("distribution length wrong");
   a_cal_len: assert property ($fell(busy) && c_q |-> dst_q == dst_len)
      else $error("calibration length wrong");
   a_valid_rise: assert property ($fell(busy) |-> ##1 $rose(result_valid))
      else $error("valid late or early");
   a_valid_hold: assert property ($fell(result_valid) |-> go_q < 4'hA)
      else $error("valid dropped without go");
   a_start_both: assert property ($rose(busy) |-> $rose(acquiring))
      else $error("start not joint");
   a_acq_in_busy: assert property (acquiring |-> busy)
      else $error("acquiring outside busy");
   a_res_stable: assert property (result_valid && $past(result_valid)
      |-> $stable(result) && $stable(result_channel))
      else $error("result moved while valid");
   c_cal_on: cover property ($fell(busy) && c_q);
   c_cal_off: cover property ($fell(busy) && !c_q);
   c_valid_clr: cover property ($fell(result_valid));
endmodule
bind acs_sequencer acs_monitor i_acs_monitor (
   .pclk           (pclk),
   .presetn        (presetn),
   .psel           (psel),
   .penable        (penable),
   .pwrite         (pwrite),
   .pready         (pready),
   .paddr          (paddr),
   .pwdata         (pwdata),
   .conversion_go  (conversion_go),
   .busy           (busy),
   .acquiring      (acquiring),
   .result_valid   (result_valid),
   .result         (result),
   .result_channel (result_channel)
);

// >>> acs_fabric_model.sv
`timescale 1ns/1ns
module acs_fabric_model (
   // Clock and status
   input wire        pclk,
   input wire        result_valid,
   // Fabric drive
   output reg        conversion_go,
   output reg [11:0] sample_in
);
   reg hold;  // Data held for a conversion
   reg rv_q;  // Valid delayed for edge detect
   initial begin
      conversion_go = 1'b0; sample_in = 12'h5A5; hold = 1'b0; rv_q = 1'b0;
   end
   // Data is only promised during a conversion: scramble it otherwise
   always @(posedge pclk) begin
      rv_q <= result_valid;
      if (!hold) sample_in <= ~sample_in;
      if (result_valid && !rv_q) hold <= 1'b0;
   end
   // Present data, optionally pulse the go pin for three cycles
   task start(input [11:0] v, input pin);
      hold = 1'b1;
      @(posedge pclk);
      sample_in <= v; conversion_go <= pin;
      repeat (3) @(posedge pclk);
      conversion_go <= 1'b0;
   endtask
endmodule

// >>> test_acs_sequencer.sv
`timescale 1ns/1ns
module test_acs_sequencer;
   reg pclk, presetn, psel, penable, pwrite;
   reg [11:0] paddr;
   reg [31:0] pwdata, r, e;
   wire [31:0] prdata;
   wire pready, pslverr, conversion_go, busy, acquiring, result_valid, irq;
   wire [11:0] sample_in, result;
   wire [4:0] result_channel;
   reg bz_q, rv_q;
   reg [14:0] lat_c;   // Cycles since busy rose
   reg [31:0] exp_q[$];
   reg [4:0] ch;
   reg [11:0] v;
   int miscompares, compares, i;
   bit [7:0] ts[4] = '{8'h00, 8'h03, 8'hFF, 8'h01};
   bit [4:0] tn[4] = '{5'h0A, 5'h08, 5'h0C, 5'h01};
   bit       tc[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   acs_sequencer i_acs_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conversion_go(conversion_go), .sample_in(sample_in), .busy(busy),
      .acquiring(acquiring), .result_valid(result_valid), .result(result),
      .result_channel(result_channel), .irq(irq));
   acs_fabric_model i_acs_fabric_model (.pclk(pclk), .result_valid(result_valid),
      .conversion_go(conversion_go), .sample_in(sample_in));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task chk(input [31:0] got, input [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task finish_test;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // One APB transfer, held until pready
   task apb(input w, input [11:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata; e = {31'h0, pslverr};
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // Result watcher: oldest note against each new result
   always @(posedge pclk) begin
      bz_q <= busy; rv_q <= result_valid;
      lat_c <= (busy && !bz_q) ? 15'h0001 : lat_c + 15'h0001;
      if (result_valid === 1'b1 && rv_q === 1'b0) begin
         if (exp_q.size() == 0) chk(32'h0, 32'h1);
         else chk({lat_c, result_channel, result}, exp_q.pop_front());
      end
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      finish_test;
   end
   initial begin
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      presetn = 1'b0; miscompares = 0; compares = 0; lat_c = 15'h0;
      v = $urandom(32'h47179e45);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h004, 32'h0);
      chk(r, 32'h00010A00);
      apb(1'b0, 12'h01C, 32'h0);
      chk(e, 32'h1);
      for (i = 0; i < 4; i++) begin
         ch = $urandom; v = $urandom;
         // Mode bit selects calibration
         apb(1'b1, 12'h004, {15'h0, tc[i], 3'h0, tn[i], ts[i]});
         apb(1'b1, 12'h014, {31'h0, i[0]});
         apb(1'b1, 12'h000, {19'h0, ch, 8'h00});
         exp_q.push_back({15'((2 + ts[i] + tn[i] + 2 * tc[i]) * 4 + 1), ch, v});
         i_acs_fabric_model.start(v, i != 1);
         if (i == 1) apb(1'b1, 12'h000, {19'h0, ch, 8'h01});
         while (exp_q.size() != 0) @(posedge pclk);
         apb(1'b0, 12'h008, 32'h0);
         chk(r, 32'h4);
         apb(1'b0, 12'h00C, 32'h0);
         chk(r, {11'h0, ch, 4'h0, v});
         apb(1'b0, 12'h010, 32'h0);
         chk(r, 32'h3);
         chk({31'h0, irq}, {31'h0, i[0]});
         apb(1'b1, 12'h018, 32'h3);
         repeat (3) @(posedge pclk);
         chk({31'h0, irq}, 32'h0);
      end
      finish_test;
   end
endmodule
